// ===== control_timer_count_output_regs_tb_top.sv
// Self-checking bench of the control timer slice
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module control_timer_count_output_regs_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        clr = 1'b0;
    logic [31:0] seed = 32'h1e6ea41c;
    logic [31:0] d;
    logic [31:0] v;
    logic        e;
    wire logic [31:0] reg_rdata;
    wire logic [7:0]  wave_out;
    wire logic [7:0]  seen_hi;
    wire logic [7:0]  seen_lo;
    int errors = 0;
    int n_tests = 0;
    ctc_core ctc_core_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wave_out(wave_out));
    ctc_power_stage ctc_power_stage_inst (.clk(clk), .rst(rst), .clr(clr),
        .wave_out(wave_out), .seen_hi(seen_hi), .seen_lo(seen_lo));
    always #5 clk = ~clk;
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // Field mask from resolution (bits 1:0) and 16-bit mode (bit 2)
    function automatic logic [23:0] cm(input logic [2:0] c);
        logic [4:0] s;
        s = (c[1:0] == 2'h0) ? 5'h00 : 5'h03 + {3'h0, c[1:0]};
        return (c[2] ? 24'h00ffff : 24'hffffff) << s;
    endfunction : cm
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= w;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask : rd
    task automatic chk(input logic [7:0] a, input logic [31:0] x, input string nm);
        logic [31:0] q;
        rd(a, q);
        `CHK(nm, x, q)
    endtask : chk
    task automatic rs();
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
    endtask : rs
    task automatic end_of_test();
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    // Watchdog cuts a hang short
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        end_of_test();
    end
    initial begin
        rs();
        chk(8'h30, 32'h1, "status");
        chk(8'h34, 32'h0, "count");
        chk(8'h38, 32'h0, "ovr");
        chk(8'h3c, 32'h0, "shape");
        chk(8'h20, 32'h0, "gap");
        // Counter load and readback over every resolution and width
        for (int m = 0; m < 8; m++) begin
            v = xs();
            wr(8'h00, {27'h0, 3'(m), 2'h0});
            wr(8'h34, v);
            repeat (2) @(posedge clk);
            wr(8'h14, 32'h80);
            chk(8'h34, {8'h00, v[23:0] & cm(3'(m))}, "count");
        end
        // Random override and shaping words, every shape and scheme code
        for (int k = 0; k < 8; k++) begin
            v = xs();
            wr(8'h38, v);
            chk(8'h38, {16'h0, v[15:0]}, "ovr");
            v = (v & 32'h0f0f0f80) | 32'(k) | (32'(k % 4) << 4);
            wr(8'h3c, v);
            chk(8'h3c, v, "shape");
        end
        wr(8'h38, 32'h0);
        // Single run: stop on update, start level, exchange, circular copies
        wr(8'h40, 32'h20);
        wr(8'h48, 32'h100);
        wr(8'h44, 32'h100);
        for (int p = 0; p < 2; p++) begin
            e = (p == 0);
            v = (p == 0 ? 32'h280 : 32'h20) | 32'h2 | (32'(p) << 16);
            wr(8'h00, 32'h2);
            wr(8'h3c, v);
            wr(8'h34, 32'hfffffe);
            wr(8'h00, 32'h3);
            repeat (20) @(posedge clk);
            rd(8'h30, d);
            `CHK("stop", 1'b1, d[0])
            `CHK("cmp0", e, d[24])
            `CHK("idx", 1'(p), d[1])
            `CHK("wave", {~e, e}, {wave_out[4], wave_out[0]})
            wr(8'h3c, v | 32'h0100_0000);
            repeat (3) @(posedge clk);
            `CHK("swap", {e, ~e}, {wave_out[4], wave_out[0]})
            if (p == 0) begin
                chk(8'h40, 32'hffffff, "cycle_length_buffer");
            end
            chk(8'h48, p == 0 ? 32'h100 : 32'h0, "cc1");
        end
        wr(8'h38, 32'ha5ff);
        repeat (3) @(posedge clk);
        `CHK("force", 8'ha5, wave_out)
        // Free-running single-slope then dual-slope bursts
        rs();
        wr(8'h40, 32'h20);
        wr(8'h44, 32'h10);
        for (int g = 2; g < 5; g += 2) begin
            wr(8'h3c, 32'(g));
            wr(8'h34, g == 2 ? 32'hfffffe : 32'h0);
            wr(8'h00, 32'h1);
            clr <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            repeat (200) @(posedge clk);
            `CHK("hi", 2'h3, {seen_hi[0], seen_lo[0]})
            chk(8'h30, g == 2 ? 32'h0100_0000 : 32'h0, "run");
            wr(8'h14, 32'h40);
            rd(8'h30, d);
            `CHK("stopcmd", 1'b1, d[0])
            wr(8'h14, 32'h20);
            rd(8'h30, d);
            `CHK("retrig", 1'b0, d[0])
            wr(8'h00, 32'h0);
        end
        end_of_test();
    end
endmodule : control_timer_count_output_regs_tb_top
bind ctc_core ctc_core_assertions #(.ADDR_W(ADDR_W)) ctc_core_assertions_inst (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wave_out(wave_out));
`default_nettype wire

// ===== ctc_core.sv
// Counter, stop status, buffered compare and output shaping of the control timer
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module ctc_core #(
    parameter int ADDR_W = 8,
    parameter int CH_NUM = 4,
    parameter int OUT_NUM = 8
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [31:0]         reg_rdata,
    output logic      [OUT_NUM-1:0]  wave_out
);

    // Field positions are fixed at four channels and eight outputs
    if (CH_NUM != 4 || OUT_NUM != 2 * CH_NUM || ADDR_W < 8) begin : g_bad
        $error("ctc_core: needs CH_NUM 4, OUT_NUM 8, ADDR_W at least 8");
    end

    // Next compare level for one channel
    function automatic logic cmp_next(
        input logic [2:0] gen,
        input logic       output_invert_select,
        input logic       dirl,
        input logic       upd,
        input logic       hit,
        input logic       cur
    );
        logic r;
        r = cur;
        case (gen)
            ctc_pkg::GEN_NFRQ,
            ctc_pkg::GEN_MFRQ: begin
                if (hit) r = ~cur;
            end
            ctc_pkg::GEN_NPWM: begin
                if (upd) r = output_invert_select ? dirl : ~dirl;
                else if (hit) r = output_invert_select ? ~dirl : dirl;
            end
            ctc_pkg::GEN_DSCR,
            ctc_pkg::GEN_DSBOT,
            ctc_pkg::GEN_DSBTH,
            ctc_pkg::GEN_DSTOP: begin
                if (hit) r = output_invert_select ? dirl : ~dirl;
            end
            default: begin
                r = cur;
            end
        endcase
        cmp_next = r;
    endfunction : cmp_next

    // Control and configuration state
    logic                 en_q;
    logic                 single_q;
    logic [1:0]           res_q;
    logic                 w16_q;
    logic [2:0]           gen_q;
    logic [1:0]           sch_q;
    logic                 cper_q;
    logic [CH_NUM-1:0]    ccc_q;
    logic [CH_NUM-1:0]    pol_q;
    logic [CH_NUM-1:0]    swap_q;
    logic [OUT_NUM-1:0]   lvl_q;
    logic [OUT_NUM-1:0]   oen_q;

    // Counting state
    logic                 run_q;
    logic                 stop_q;
    logic                 dir_q;
    logic                 idx_q;
    logic [23:0]          count_q;
    logic [23:0]          count_d;
    logic                 ld_q;
    logic [23:0]          ld_val_q;
    logic [23:0]          snap_q;
    logic [23:0]          per_act_q;
    logic [23:0]          per_buf_q;
    logic [23:0]          cc_act_q [CH_NUM];
    logic [23:0]          cc_buf_q [CH_NUM];
    logic [CH_NUM-1:0]    cmp_q;
    logic [CH_NUM-1:0]    cmp_d;
    logic [31:0]          rdata_q;

    // Address decode; upper address bits must be zero, and 0x40 is the period buffer, not a channel
    wire hi_zero  = (ADDR_W > 8) ? (reg_addr >> 8) == '0 : 1'b1;
    wire wr_ctrl  = reg_wr && hi_zero && reg_addr[7:0] == ctc_pkg::OFS_CTRL;
    wire wr_cmd   = reg_wr && hi_zero && reg_addr[7:0] == ctc_pkg::OFS_CMD;
    wire wr_count = reg_wr && hi_zero && reg_addr[7:0] == ctc_pkg::OFS_COUNT;
    wire wr_ovr   = reg_wr && hi_zero && reg_addr[7:0] == ctc_pkg::OFS_OVR;
    wire wr_shape = reg_wr && hi_zero && reg_addr[7:0] == ctc_pkg::OFS_SHAPE;
    wire wr_cycle_length_buffer  = reg_wr && hi_zero && reg_addr[7:0] == ctc_pkg::OFS_CYCLE_LENGTH_BUFFER;
    wire cc_sel   = hi_zero && reg_addr[7:4] == ctc_pkg::OFS_CC0[7:4]
                    && reg_addr[1:0] == 2'h0 && reg_addr[3:2] != 2'h0
                    || hi_zero && reg_addr[7:0] == 8'h50;
    wire [1:0] cc_idx = reg_addr[7:0] == 8'h50 ? 2'h3 : 2'(reg_addr[3:2] - 2'h1);
    wire wr_cc    = reg_wr && cc_sel;

    // Command decode
    wire [2:0] cmd    = reg_wdata[ctc_pkg::CMD_LSB +: 3];
    wire cmd_stop     = wr_cmd && cmd == ctc_pkg::CMD_STOP;
    wire cmd_retrig   = wr_cmd && cmd == ctc_pkg::CMD_RETRIG;
    wire cmd_rdsync   = wr_cmd && cmd == ctc_pkg::CMD_RDSYNC;

    // Field placement for the chosen resolution and width
    wire [23:0] mask  = ctc_pkg::fld_mask(res_q, w16_q);
    wire [23:0] step  = 24'h000001 << ctc_pkg::fld_lsb(res_q);
    wire [23:0] cnt_m = count_q & mask;

    // Mode decode
    wire dual      = gen_q[2];
    wire mfrq      = gen_q == ctc_pkg::GEN_MFRQ;
    wire two_cyc   = sch_q == ctc_pkg::SCH_ALT2 || sch_q == ctc_pkg::SCH_TWO;
    wire [23:0] top = (mfrq ? cc_act_q[0] : per_act_q) & mask;

    // A pending counter load takes this cycle instead of a count step
    wire tick      = run_q && en_q && !ld_q;
    wire at_top    = cnt_m >= top;
    wire at_zero   = cnt_m == 24'h000000;
    wire upd_s     = tick && !dual && at_top;
    wire turn_top  = tick && dual && !dir_q && at_top;
    wire turn_bot  = tick && dual && dir_q && at_zero;
    wire upd       = upd_s || turn_bot
                     || (turn_top && gen_q == ctc_pkg::GEN_DSBTH);
    wire going_up  = dual ? (dir_q ? turn_bot : !turn_top) : 1'b1;

    // Stop and restart causes
    wire dis_wr    = wr_ctrl && en_q && !reg_wdata[ctc_pkg::CTRL_EN];
    wire en_wr     = wr_ctrl && !en_q && reg_wdata[ctc_pkg::CTRL_EN];
    wire stop_set  = cmd_stop || dis_wr || (upd && single_q);
    wire start     = cmd_retrig || en_wr;

    // Next counter value, restart returns to bottom counting up
    always_comb begin
        if (ld_q) begin
            count_d = ld_val_q;
        end else if (cmd_retrig) begin
            count_d = ctc_pkg::CNT_RST;
        end else if (!tick) begin
            count_d = count_q;
        end else if (upd_s) begin
            count_d = ctc_pkg::CNT_RST;
        end else if (going_up) begin
            count_d = (count_q + step) & mask;
        end else begin
            count_d = (count_q - step) & mask;
        end
    end

    // Compare levels, two-cycle schemes hold a channel in its off cycle
    always_comb begin
        for (int i = 0; i < CH_NUM; i++) begin
            cmp_d[i] = cmp_next(gen_q, pol_q[i], dir_q, upd,
                                tick && cnt_m == (cc_act_q[i] & mask), cmp_q[i]);
            if (two_cyc && ((i == 0 && idx_q) || (i == 1 && !idx_q))) begin
                cmp_d[i] = cmp_q[i];
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clk) begin
        if (rst) begin
            en_q     <= 1'b0;
            single_q <= 1'b0;
            res_q    <= 2'h0;
            w16_q    <= 1'b0;
        end else if (wr_ctrl) begin
            en_q     <= reg_wdata[ctc_pkg::CTRL_EN];
            single_q <= reg_wdata[ctc_pkg::CTRL_SINGLE];
            res_q    <= reg_wdata[ctc_pkg::CTRL_RES_LSB +: 2];
            w16_q    <= reg_wdata[ctc_pkg::CTRL_W16];
        end
    end

    // Output shaping control, shape and scheme act without synchronising
    always_ff @(posedge clk) begin
        if (rst) begin
            gen_q  <= ctc_pkg::GEN_NFRQ;
            sch_q  <= ctc_pkg::SCH_ONE;
            cper_q <= 1'b0;
            ccc_q  <= '0;
            pol_q  <= '0;
            swap_q <= '0;
        end else if (wr_shape) begin
            gen_q  <= reg_wdata[ctc_pkg::SH_GEN_LSB +: 3];
            sch_q  <= reg_wdata[ctc_pkg::SH_SCH_LSB +: 2];
            cper_q <= reg_wdata[ctc_pkg::SH_CPER];
            ccc_q  <= reg_wdata[ctc_pkg::SH_CCC_LSB +: CH_NUM];
            pol_q  <= reg_wdata[ctc_pkg::SH_POL_LSB +: CH_NUM];
            swap_q <= reg_wdata[ctc_pkg::SH_SWAP_LSB +: CH_NUM];
        end
    end

    // Forced-level register
    always_ff @(posedge clk) begin
        if (rst) begin
            lvl_q <= '0;
            oen_q <= '0;
        end else if (wr_ovr) begin
            lvl_q <= reg_wdata[ctc_pkg::OVR_LVL_LSB +: OUT_NUM];
            oen_q <= reg_wdata[ctc_pkg::OVR_EN_LSB +: OUT_NUM];
        end
    end

    // Run control; a set of the stopped flag wins over a same-cycle step
    always_ff @(posedge clk) begin
        if (rst) begin
            run_q  <= 1'b0;
            stop_q <= 1'b1;
        end else begin
            if (stop_set) begin
                run_q <= 1'b0;
            end else if (start) begin
                run_q <= 1'b1;
            end
            if (stop_set) begin
                stop_q <= 1'b1;
            end else if (tick) begin
                stop_q <= 1'b0;
            end
        end
    end

    // Counter write is held one cycle before it reaches the counter
    always_ff @(posedge clk) begin
        if (rst) begin
            ld_q     <= 1'b0;
            ld_val_q <= ctc_pkg::CNT_RST;
        end else begin
            ld_q     <= wr_count;
            ld_val_q <= reg_wdata[23:0] & mask;
        end
    end

    // Counter, direction and cycle index
    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= ctc_pkg::CNT_RST;
            dir_q   <= 1'b0;
            idx_q   <= 1'b0;
        end else begin
            count_q <= count_d;
            if (cmd_retrig || !dual) begin
                dir_q <= 1'b0;
            end else if (turn_top) begin
                dir_q <= 1'b1;
            end else if (turn_bot) begin
                dir_q <= 1'b0;
            end
            if (!two_cyc) begin
                idx_q <= 1'b0;
            end else if (upd) begin
                idx_q <= ~idx_q;
            end
        end
    end

    // Snapshot read by software, taken only on the read-sync command
    always_ff @(posedge clk) begin
        if (rst) begin
            snap_q <= ctc_pkg::CNT_RST;
        end else if (cmd_rdsync) begin
            snap_q <= cnt_m;
        end
    end

    // Period buffer and active period; a bus write beats the copy-back
    always_ff @(posedge clk) begin
        if (rst) begin
            per_act_q <= ctc_pkg::PER_RST;
            per_buf_q <= ctc_pkg::PER_RST;
        end else begin
            if (upd) begin
                per_act_q <= per_buf_q;
            end
            if (wr_cycle_length_buffer) begin
                per_buf_q <= reg_wdata[23:0] & mask;
            end else if (upd && cper_q) begin
                per_buf_q <= per_act_q;
            end
        end
    end

    // Compare buffers per channel, alternating when circular
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < CH_NUM; i++) begin
                cc_act_q[i] <= ctc_pkg::CC_RST;
                cc_buf_q[i] <= ctc_pkg::CC_RST;
            end
        end else begin
            for (int i = 0; i < CH_NUM; i++) begin
                if (upd) begin
                    cc_act_q[i] <= cc_buf_q[i];
                end
                if (wr_cc && cc_idx == 2'(i)) begin
                    cc_buf_q[i] <= reg_wdata[23:0] & mask;
                end else if (upd && ccc_q[i]) begin
                    cc_buf_q[i] <= cc_act_q[i];
                end
            end
        end
    end

    // Compare output levels
    always_ff @(posedge clk) begin
        if (rst) begin
            cmp_q <= '0;
        end else begin
            cmp_q <= cmp_d;
        end
    end

    // Read data selection, unmapped offsets and write-only command read zero
    wire [31:0] rd_ctrl  = {27'h0, w16_q, res_q, single_q, en_q};
    wire [31:0] rd_stat  = {4'h0, cmp_q, 22'h0, idx_q, stop_q};
    wire [31:0] rd_ovr   = {16'h0, lvl_q, oen_q};
    wire [31:0] rd_shape = {4'h0, swap_q, 4'h0, pol_q, 4'h0, ccc_q,
                            cper_q, 1'b0, sch_q, 1'b0, gen_q};
    wire [7:0]  ra       = reg_addr[7:0];
    wire [31:0] rd_val   =
        !hi_zero                   ? 32'h00000000 :
        ra == ctc_pkg::OFS_CTRL    ? rd_ctrl :
        ra == ctc_pkg::OFS_STATUS  ? rd_stat :
        ra == ctc_pkg::OFS_COUNT   ? {8'h00, snap_q} :
        ra == ctc_pkg::OFS_OVR     ? rd_ovr :
        ra == ctc_pkg::OFS_SHAPE   ? rd_shape :
        ra == ctc_pkg::OFS_CYCLE_LENGTH_BUFFER    ? {8'h00, per_buf_q & mask} :
        cc_sel                     ? {8'h00, cc_act_q[cc_idx] & mask} :
                                     32'h00000000;

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
        end else if (reg_rd) begin
            rdata_q <= rd_val;
        end else begin
            rdata_q <= 32'h00000000;
        end
    end

    assign reg_rdata = rdata_q;

    // Exchange and override stage towards the pins
    ctc_out_stage #(
        .PAIRS    (CH_NUM)
    ) u_out (
        .clk      (clk),
        .rst      (rst),
        .cmp      (cmp_q),
        .swap     (swap_q),
        .ovr_lvl  (lvl_q),
        .ovr_en   (oen_q),
        .wave_out (wave_out)
    );

endmodule : ctc_core

`default_nettype wire

// ===== ctc_core_assertions.sv
// Port-level checker of the control timer slice
`timescale 1ns/1ps
`default_nettype none
module ctc_core_assertions #(
    parameter int ADDR_W = 8
) (
    input wire logic              clk,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    input wire logic [7:0]        wave_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Decode of the offsets watched here
    wire logic h_ctl = reg_addr == ADDR_W'(8'h00);
    wire logic h_cmd = reg_addr == ADDR_W'(8'h14);
    wire logic h_st  = reg_addr == ADDR_W'(8'h30);
    wire logic h_cnt = reg_addr == ADDR_W'(8'h34);
    wire logic h_ovr = reg_addr == ADDR_W'(8'h38);
    wire logic h_shp = reg_addr == ADDR_W'(8'h3c);
    wire logic h_gap = reg_addr == ADDR_W'(8'h20);
    logic [15:0] ovr_q;
    logic [2:0]  fmt_q;
    logic [1:0]  age_q;
    wire logic [4:0]  lsb = (fmt_q[1:0] == 2'h0) ? 5'h00 : 5'h03 + {3'h0, fmt_q[1:0]};
    wire logic [23:0] msk = (fmt_q[2] ? 24'h00ffff : 24'hffffff) << lsb;
    // Shadows of what software wrote; age lets the output pipe settle first
    always_ff @(posedge clk) begin
        if (rst) begin
            ovr_q <= 16'h0000;
            fmt_q <= 3'h0;
            age_q <= 2'h0;
        end else begin
            ovr_q <= (reg_wr && h_ovr) ? reg_wdata[15:0] : ovr_q;
            fmt_q <= (reg_wr && h_ctl) ? reg_wdata[4:2] : fmt_q;
            age_q <= (reg_wr && h_ovr) ? 2'h0 : age_q + {1'b0, age_q != 2'h3};
        end
    end
    sequence s_rd(logic hit);
        reg_rd && hit;
    endsequence
    sequence s_stop;
        reg_wr && h_cmd && reg_wdata[7:5] == 3'h2;
    endsequence
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
    property p_gap;
        s_rd(h_gap || h_cmd) |=> reg_rdata == 32'h0;
    endproperty
    a_gap: assert property (p_gap) else $error("unmapped or command read not zero");
    property p_cnt_mask;
        s_rd(h_cnt) |=> (reg_rdata & ~{8'h00, $past(msk)}) == 32'h0;
    endproperty
    a_cnt_mask: assert property (p_cnt_mask) else $error("count bits outside field");
    property p_shp_rsv;
        s_rd(h_shp) |=> (reg_rdata & 32'hf0f0f048) == 32'h0;
    endproperty
    a_shp_rsv: assert property (p_shp_rsv) else $error("shaping unused bits set");
    property p_ovr_hi;
        s_rd(h_ovr) |=> reg_rdata == {16'h0000, $past(ovr_q)};
    endproperty
    a_ovr_hi: assert property (p_ovr_hi) else $error("override readback wrong");
    property p_ovr_out;
        age_q == 2'h3 |-> ((wave_out ^ ovr_q[15:8]) & ovr_q[7:0]) == 8'h00;
    endproperty
    a_ovr_out: assert property (p_ovr_out) else $error("forced level not on output");
    property p_pair_cpl;
        age_q == 2'h3 && ovr_q[7:0] == 8'h00 |-> wave_out[7:4] == ~wave_out[3:0];
    endproperty
    a_pair_cpl: assert property (p_pair_cpl) else $error("pair not complementary");
    property p_stop_cmd;
        s_stop ##2 s_rd(h_st) |=> reg_rdata[0];
    endproperty
    a_stop_cmd: assert property (p_stop_cmd) else $error("stop flag not set");
endmodule : ctc_core_assertions
`default_nettype wire

// ===== ctc_out_stage.sv
// Pair exchange and forced-level override of the waveform outputs
`timescale 1ns/1ps
`default_nettype none

module ctc_out_stage #(
    parameter int PAIRS = 4
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic [PAIRS-1:0]     cmp,
    input  wire logic [PAIRS-1:0]     swap,
    input  wire logic [2*PAIRS-1:0]   ovr_lvl,
    input  wire logic [2*PAIRS-1:0]   ovr_en,
    output logic      [2*PAIRS-1:0]   wave_out
);

    logic [2*PAIRS-1:0] pre;
    logic [2*PAIRS-1:0] swp;
    logic [2*PAIRS-1:0] fin;

    // Low half carries the compare level, high half its complement
    assign pre = {~cmp, cmp};

    // Exchange per pair, dead-time enables play no part here
    for (genvar i = 0; i < PAIRS; i++) begin : g_pair
        assign swp[i]       = swap[i] ? pre[i+PAIRS] : pre[i];
        assign swp[i+PAIRS] = swap[i] ? pre[i] : pre[i+PAIRS];
    end

    // Override sits after the exchange so a forced level stays on its pin
    assign fin = (ovr_en & ovr_lvl) | (~ovr_en & swp);

    // Registered so the pins never glitch on a mode change
    always_ff @(posedge clk) begin
        if (rst) begin
            wave_out <= '0;
        end else begin
            wave_out <= fin;
        end
    end

endmodule : ctc_out_stage

`default_nettype wire

// ===== ctc_pkg.sv
// Constants, register map and field layout of the control timer slice
// How it works
// - Stopped flag sets on stop command, disable, or update in single-run mode.
// - Stopped flag clears on the next count step; 1 stopped, 0 running.
// - In 16-bit mode counter bits above the field width read as zero.
// - In 24-bit mode counter field sits at 23:0, 23:4, 23:5 or 23:6 by resolution.
// - Override register: levels in upper byte, enables in lower byte.
// - An enabled override replaces the exchanged output with its level bit.
// - Pair exchange bit x swaps outputs x and x+4, dead-time ignored.
// - Single-slope: polarity 0 starts at not-dir, match drives dir; 1 reversed.
// - Dual-slope: match drives not-dir with polarity 0, dir with polarity 1.
// - Circular compare enable copies active compare value back on update.
// - Circular period enable copies active period back to buffer on update.
// - Cycle scheme: 0 single, 1 alternative two-cycle, 2 two-cycle, 3 reserved.
// - Output shape field selects frequency, match, PWM and dual-slope modes.
`default_nettype none

package ctc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_CMD    = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h30;
    localparam logic [7:0] OFS_COUNT  = 8'h34;
    localparam logic [7:0] OFS_OVR    = 8'h38;
    localparam logic [7:0] OFS_SHAPE  = 8'h3c;
    localparam logic [7:0] OFS_CYCLE_LENGTH_BUFFER   = 8'h40;
    localparam logic [7:0] OFS_CC0    = 8'h44;

    // Control register fields
    localparam int CTRL_EN      = 0;
    localparam int CTRL_SINGLE  = 1;
    localparam int CTRL_RES_LSB = 2;
    localparam int CTRL_W16     = 4;

    // Command field and its codes
    localparam int CMD_LSB = 5;
    typedef enum logic [2:0] {
        CMD_NONE    = 3'h0,
        CMD_RETRIG  = 3'h1,
        CMD_STOP    = 3'h2,
        CMD_RDSYNC  = 3'h4
    } ctc_cmd_t;

    // Status fields
    localparam int ST_STOP    = 0;
    localparam int ST_IDX     = 1;
    localparam int ST_CMP_LSB = 24;

    // Output shaping control fields
    localparam int SH_GEN_LSB   = 0;
    localparam int SH_SCH_LSB   = 4;
    localparam int SH_CPER      = 7;
    localparam int SH_CCC_LSB   = 8;
    localparam int SH_POL_LSB   = 16;
    localparam int SH_SWAP_LSB  = 24;

    // Override register fields
    localparam int OVR_EN_LSB  = 0;
    localparam int OVR_LVL_LSB = 8;

    // Output shape selections
    typedef enum logic [2:0] {
        GEN_NFRQ  = 3'h0,
        GEN_MFRQ  = 3'h1,
        GEN_NPWM  = 3'h2,
        GEN_RSVD  = 3'h3,
        GEN_DSCR  = 3'h4,
        GEN_DSBOT = 3'h5,
        GEN_DSBTH = 3'h6,
        GEN_DSTOP = 3'h7
    } ctc_gen_t;

    // Cycle schemes
    typedef enum logic [1:0] {
        SCH_ONE   = 2'h0,
        SCH_ALT2  = 2'h1,
        SCH_TWO   = 2'h2,
        SCH_RSVD  = 2'h3
    } ctc_sch_t;

    // Reset values
    localparam logic [23:0] CNT_RST = 24'h000000;
    localparam logic [23:0] PER_RST = 24'hffffff;
    localparam logic [23:0] CC_RST  = 24'h000000;

    // Lowest bit of the value field for a resolution setting
    function automatic logic [4:0] fld_lsb(input logic [1:0] res);
        fld_lsb = (res == 2'h0) ? 5'h00 : (5'h03 + {3'h0, res});
    endfunction : fld_lsb

    // Bits of a 24-bit value that hold the field
    function automatic logic [23:0] fld_mask(input logic [1:0] res, input logic w16);
        logic [23:0] m;
        m = 24'hffffff << fld_lsb(res);
        if (w16) begin
            m = m & (24'h00ffff << fld_lsb(res));
        end
        fld_mask = m;
    endfunction : fld_mask

endpackage : ctc_pkg

`default_nettype wire

// ===== ctc_power_stage.sv
// Behavioural power stage that records the levels each output has shown
`timescale 1ns/1ps
`default_nettype none
module ctc_power_stage (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       clr,
    input  wire logic [7:0] wave_out,
    output logic      [7:0] seen_hi,
    output logic      [7:0] seen_lo
);
    // Sticky record, cleared between bursts so each burst is judged alone
    always_ff @(posedge clk) begin
        if (rst || clr) begin
            seen_hi <= 8'h00;
            seen_lo <= 8'h00;
        end else begin
            seen_hi <= seen_hi | wave_out;
            seen_lo <= seen_lo | ~wave_out;
        end
    end
endmodule : ctc_power_stage
`default_nettype wire
